// [logic/srd_rx_deser.sv]
// Purpose: Sixteen-lane SDR receive deserializer with per-lane alignment
// Assumes: CLK_SYS is the fast sample clock; word rates are enables from a divide-by-four
// Notes:   Registers over APB; one level interrupt
// Behaviour
// [RULE_01] Sixteen lane deserializers share one receive clock.
// [RULE_02] Each lane turns its serial stream into 4-bit words, one bit per cycle.
// [RULE_03] All lane words form one 64-bit word for the system side.
// [RULE_04] Word rate is the fast clock divided by four.
// [RULE_05] Fast clock samples serial inputs; word rate clocks parallel outputs.
// [RULE_06] Slot one holds the newest bit, slot four the oldest.
// [RULE_07] With slip search on, slip until the lane word equals the expected word.
// [RULE_08] Each lane has its own engine for its delay and slip.
// [RULE_09] Lane locked goes high when that lane finishes alignment.
// [RULE_10] Bus locked is high only when every lane has finished.
// [RULE_11] Clock request is high while a clock pattern is needed on the lanes.
// [RULE_12] Logic reset clears control logic; deserializer reset clears deserializers.
// [RULE_13] Sample clock enable low stops capture of new words.
// [RULE_14] Delay-based alignment waits for delay ready.
// [RULE_15] A FIFO carries words from receive word rate to system word rate.
// [RULE_16] Slip, delay step up, step enable and reload come from logic; delay variable.
// [RULE_17] Locked/request pair: 00 word align, 01 bit align, 10 or 11 finished.
// [RULE_18] Lane n occupies bits 4n+3 down to 4n of the 64-bit word.
// [RULE_19] FIFO written only with aligned data, read at every system word slot.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
module srd_rx_deser
  import srd_pkg::*;
(
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_N,
  input  wire logic                 LOGIC_RESET,
  input  wire logic                 DESER_RESET,
  input  wire logic                 DELAY_READY,
  input  wire logic [NUM_LANES-1:0] LANE_IN_POS,
  input  wire logic [NUM_LANES-1:0] LANE_IN_NEG,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  output logic      [BUS_BITS-1:0]  DATA_OUT,
  output logic                      DATA_VALID,
  output logic      [NUM_LANES-1:0] LANE_LOCKED,
  output logic                      BUS_LOCKED,
  output logic                      CLOCK_REQUEST,
  output logic                      IRQ
);
  // Pin synchronisers; first stage feeds only the second
  logic [2*NUM_LANES+2:0] pin_s1_r, pin_s2_r;
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= {LOGIC_RESET, DESER_RESET, DELAY_READY, LANE_IN_NEG, LANE_IN_POS};
      pin_s2_r <= pin_s1_r;
    end
  end
  wire                 logic_rst   = pin_s2_r[2*NUM_LANES+2];  // [RULE_12]
  wire                 deser_rst   = pin_s2_r[2*NUM_LANES+1];  // [RULE_12]
  wire                 delay_ready = pin_s2_r[2*NUM_LANES];
  wire [NUM_LANES-1:0] lane_bit    = pin_s2_r[NUM_LANES-1:0] & ~pin_s2_r[2*NUM_LANES-1:NUM_LANES];

  // APB decode
  logic [1:0]          ctrl_r;
  logic [3:0]          pattern_r;
  logic [IRQ_BITS-1:0] irq_stat_r, irq_en_r;
  wire apb_acc   = PSEL && PENABLE;
  wire wr_ctrl   = apb_acc && PWRITE && (PADDR == OFS_CTRL);
  wire wr_clr    = apb_acc && PWRITE && (PADDR == OFS_IRQ_CLR);
  wire wr_en     = apb_acc && PWRITE && (PADDR == OFS_IRQ_EN);
  wire hit       = (PADDR == OFS_CTRL) || (PADDR == OFS_STATUS) || (PADDR == OFS_IRQ_STAT)
                   || (PADDR == OFS_IRQ_CLR) || (PADDR == OFS_IRQ_EN);
  wire restart   = wr_ctrl && PWDATA[CTRL_RESTART];
  wire slip_search_enable  = ctrl_r[CTRL_SLIP_BIT];
  wire sample_clock_enable = ctrl_r[CTRL_SCE_BIT];
  wire [31:0] rd_ctrl   = {23'h0, 1'b0, pattern_r, 2'h0, ctrl_r};
  wire [31:0] rd_status = {14'h0, CLOCK_REQUEST, BUS_LOCKED, LANE_LOCKED};
  assign PRDATA  = !PWRITE && PADDR == OFS_CTRL     ? rd_ctrl :
                   !PWRITE && PADDR == OFS_STATUS   ? rd_status :
                   !PWRITE && PADDR == OFS_IRQ_STAT ? {29'h0, irq_stat_r} :
                   !PWRITE && PADDR == OFS_IRQ_EN   ? {29'h0, irq_en_r} : 32'h0;
  assign PREADY  = 1'b1;
  assign PSLVERR = apb_acc && !hit;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl_r    <= CTRL_LOW_RST;
      pattern_r <= CTRL_PAT_RST;
      irq_en_r  <= IRQ_EN_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_r    <= PWDATA[1:0];
        pattern_r <= PWDATA[CTRL_PAT_LSB +: 4];
      end
      if (wr_en)
        irq_en_r <= PWDATA[IRQ_BITS-1:0];
    end
  end

  // Divide by four: word enable and a system word slot two cycles later
  logic [1:0] div_r;
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      div_r <= '0;
    else
      div_r <= div_r + 2'h1;  // [RULE_04]
  end
  wire word_en = (div_r == DIV_LAST);   // [RULE_04]
  wire sys_en  = (div_r == SYS_PHASE);

  // Word search waits until the clock pattern has drained from every lane pipe
  logic [3:0] quiet_r;
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      quiet_r <= '0;
    else if (CLOCK_REQUEST)
      quiet_r <= '0;
    else if (quiet_r != QUIET_LAST)
      quiet_r <= quiet_r + 4'h1;
  end
  wire quiet = (quiet_r == QUIET_LAST);  // [RULE_11]

  // Per-lane deserializer, delay line and alignment engine
  logic [WORD_BITS-1:0] lane_word [NUM_LANES];
  logic [NUM_LANES-1:0] lane_req, lane_slip;
  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++)
    begin : g_lane  // [RULE_01]
      logic [TAP_MAX:0]      dly_r;
      logic [TAP_BITS-1:0]   tap_r, half_r;
      logic [3:0]            sh_r, word_r;
      logic [1:0]            cnt_r;
      logic                  prev_r, settle_r, strobe_r;
      srd_state_e            st_r, st_nxt;
      wire delayed   = dly_r[tap_r];  // [RULE_16]
      wire slip_p    = (st_r == SRD_WORD) && strobe_r && !settle_r && slip_search_enable
                       && quiet && (word_r != pattern_r);  // [RULE_07]
      wire cap       = sample_clock_enable && !slip_p && (cnt_r == CAP_PHASE);  // [RULE_13]
      wire edge_f    = prev_r && !word_r[0];
      wire at_max    = (tap_r == TAP_MAX);
      wire step_up   = strobe_r && ((st_r == SRD_EDGE1 && !edge_f && !at_max)
                       || (st_r == SRD_EDGE2 && !edge_f && !at_max));  // [RULE_16]
      wire step_dn   = strobe_r && (st_r == SRD_CENTER) && (half_r != '0);
      wire step_ce   = step_up || step_dn;  // [RULE_16]
      wire reload    = (st_r == SRD_WAIT) && delay_ready;  // [RULE_16]

      always_ff @(posedge CLK_SYS or negedge RST_N)
      begin
        if (!RST_N)
        begin
          dly_r    <= '0;
          sh_r     <= '0;
          word_r   <= '0;
          cnt_r    <= '0;
          strobe_r <= 1'b0;
        end
        else if (deser_rst)
        begin
          dly_r    <= '0;
          sh_r     <= '0;
          word_r   <= '0;
          cnt_r    <= '0;
          strobe_r <= 1'b0;
        end
        else
        begin
          dly_r    <= {dly_r[TAP_MAX-1:0], lane_bit[g]};  // [RULE_05]
          strobe_r <= cap;
          if (sample_clock_enable && !slip_p)
          begin
            sh_r  <= {sh_r[2:0], delayed};  // [RULE_02] [RULE_06]
            cnt_r <= cnt_r + 2'h1;
          end
          if (cap)
            word_r <= {sh_r[2:0], delayed};  // [RULE_06]
        end
      end

      always_comb
      begin
        st_nxt = st_r;
        unique case (st_r)
          SRD_WAIT:   if (delay_ready) st_nxt = SRD_EDGE1;  // [RULE_14]
          SRD_EDGE1:  if (strobe_r && (edge_f || at_max))
                        st_nxt = at_max && !edge_f ? SRD_WORD : SRD_EDGE2;
          SRD_EDGE2:  if (strobe_r && (edge_f || at_max)) st_nxt = SRD_CENTER;
          SRD_CENTER: if (strobe_r && half_r == '0) st_nxt = SRD_WORD;
          SRD_WORD:   if (strobe_r && !settle_r && quiet && (!slip_search_enable
                          || word_r == pattern_r)) st_nxt = SRD_DONE;  // [RULE_07]
          SRD_DONE:   st_nxt = SRD_DONE;
          default:    st_nxt = SRD_WAIT;
        endcase
      end

      always_ff @(posedge CLK_SYS or negedge RST_N)
      begin
        if (!RST_N)
        begin
          st_r     <= SRD_WAIT;
          tap_r    <= '0;
          half_r   <= '0;
          prev_r   <= 1'b0;
          settle_r <= 1'b0;
        end
        else if (logic_rst || restart)
        begin
          st_r     <= SRD_WAIT;  // [RULE_12]
          tap_r    <= '0;
          half_r   <= '0;
          prev_r   <= 1'b0;
          settle_r <= 1'b0;
        end
        else
        begin
          st_r <= st_nxt;  // [RULE_08]
          if (reload)
            tap_r <= '0;
          else if (step_up)
            tap_r <= tap_r + 3'h1;
          else if (step_dn)
            tap_r <= tap_r - 3'h1;
          if (strobe_r)
            prev_r <= word_r[0];
          // Width counted in taps, centre is half way back
          if (strobe_r && st_r == SRD_EDGE1)
            half_r <= '0;
          else if (strobe_r && st_r == SRD_EDGE2)
            half_r <= edge_f ? {1'b0, half_r[TAP_BITS-1:1]} : half_r + 3'h1;
          else if (step_dn)
            half_r <= half_r - 3'h1;
          // Give one word after a slip so the new boundary is seen
          if (slip_p)
            settle_r <= 1'b1;
          else if (strobe_r)
            settle_r <= 1'b0;
        end
      end

      assign lane_word[g]   = word_r;
      assign LANE_LOCKED[g] = (st_r == SRD_DONE);  // [RULE_09] [RULE_17]
      assign lane_req[g]    = (st_r == SRD_EDGE1) || (st_r == SRD_EDGE2)
                              || (st_r == SRD_CENTER);  // [RULE_11] [RULE_17]
      assign lane_slip[g]   = slip_p;
    end
  endgenerate

  assign BUS_LOCKED    = &LANE_LOCKED;  // [RULE_10]
  assign CLOCK_REQUEST = |lane_req;     // [RULE_11]

  // Assemble the bus word
  logic [BUS_BITS-1:0] bus_word;
  generate
    for (g = 0; g < NUM_LANES; g++)
    begin : g_pack
      assign bus_word[WORD_BITS*g +: WORD_BITS] = lane_word[g];  // [RULE_18] [RULE_03]
    end
  endgenerate

  // Crossing FIFO; equal rates keep it shallow
  logic [BUS_BITS-1:0] fifo_mem [2**FIFO_AW];
  logic [FIFO_AW:0]    wp_r, rp_r;
  wire fifo_empty = (wp_r == rp_r);
  wire fifo_full  = (wp_r[FIFO_AW] != rp_r[FIFO_AW]) && (wp_r[FIFO_AW-1:0] == rp_r[FIFO_AW-1:0]);
  wire push_req   = word_en && BUS_LOCKED;   // [RULE_19]
  wire push       = push_req && !fifo_full;  // [RULE_15]
  wire pop        = sys_en && !fifo_empty;   // [RULE_19]
  wire overflow   = push_req && fifo_full;
  wire underflow  = sys_en && fifo_empty && BUS_LOCKED;
  logic bus_locked_d_r;

  always_ff @(posedge CLK_SYS)
  begin
    if (push)
      fifo_mem[wp_r[FIFO_AW-1:0]] <= bus_word;  // [RULE_15]
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wp_r       <= '0;
      rp_r       <= '0;
      DATA_OUT   <= '0;
      DATA_VALID <= 1'b0;
    end
    else if (logic_rst)
    begin
      wp_r       <= '0;
      rp_r       <= '0;
      DATA_VALID <= 1'b0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 3'h1;
      if (pop)
      begin
        rp_r     <= rp_r + 3'h1;
        DATA_OUT <= fifo_mem[rp_r[FIFO_AW-1:0]];  // [RULE_03]
      end
      DATA_VALID <= pop;
    end
  end

  // Interrupts: set wins over clear
  wire [IRQ_BITS-1:0] irq_set = {underflow, overflow, BUS_LOCKED && !bus_locked_d_r};
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      irq_stat_r     <= '0;
      bus_locked_d_r <= 1'b0;
      IRQ            <= 1'b0;
    end
    else
    begin
      bus_locked_d_r <= BUS_LOCKED;
      irq_stat_r     <= (irq_stat_r & ~(wr_clr ? PWDATA[IRQ_BITS-1:0] : '0)) | irq_set;
      IRQ            <= |(irq_stat_r & irq_en_r);
    end
  end

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_slip;
    (g_lane[0].st_r == SRD_WORD) && lane_slip[0];
  endsequence

  bus_lock_all_a: assert property (BUS_LOCKED == (&LANE_LOCKED))  // [RULE_10]
    else $error("bus locked disagrees with lanes");
  lock_req_code_a: assert property (LANE_LOCKED[0] |-> !lane_req[0])  // [RULE_17]
    else $error("finished lane still requests clock");
  word_rate_a: assert property (word_en |=> !word_en [*3] ##1 word_en)  // [RULE_04]
    else $error("word enable not every fourth cycle");
  sce_gate_a: assert property (!sample_clock_enable && !deser_rst |=> $stable(g_lane[0].word_r))  // [RULE_13]
    else $error("capture while sample enable low");
  ready_wait_a: assert property (!delay_ready |-> !g_lane[0].step_ce)  // [RULE_14]
    else $error("delay stepped before ready");
  slip_match_a: assert property (s_slip |-> slip_search_enable
    && g_lane[0].word_r != pattern_r)  // [RULE_07]
    else $error("slip with pattern already found");
  newest_bit_a: assert property (g_lane[0].cap && !deser_rst
    |=> lane_word[0][0] == $past(g_lane[0].delayed))  // [RULE_06]
    else $error("slot one not newest bit");
  fifo_write_a: assert property (push |-> BUS_LOCKED && word_en)  // [RULE_19]
    else $error("fifo written without alignment");
  fifo_read_a: assert property (sys_en && !fifo_empty && !logic_rst |=> DATA_VALID)  // [RULE_15]
    else $error("fifo not drained");
  lane_pack_a: assert property (pop && !logic_rst |=> DATA_OUT[7:4] == $past(fifo_mem[rp_r[1:0]][7:4]))  // [RULE_18]
    else $error("lane word misplaced");
endmodule : srd_rx_deser

// [common/srd_pkg.sv]
// Purpose: Shared constants for the sixteen-lane receive deserializer
// Assumes: APB slave with 32-bit data, zero wait states
// Notes:   All offsets are byte addresses
package srd_pkg;
  localparam int unsigned NUM_LANES      = 16;
  localparam int unsigned WORD_BITS      = 4;
  localparam int unsigned BUS_BITS       = 64;
  localparam int unsigned TAP_BITS       = 3;
  localparam int unsigned FIFO_AW        = 2;
  localparam logic [1:0]  DIV_LAST       = 2'h3;
  localparam logic [1:0]  SYS_PHASE      = 2'h1;
  localparam logic [1:0]  CAP_PHASE      = 2'h3;
  localparam logic [2:0]  TAP_MAX        = 3'h7;
  localparam logic [3:0]  QUIET_LAST     = 4'hF;
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STAT   = 8'h08;
  localparam logic [7:0]  OFS_IRQ_CLR    = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_EN     = 8'h10;
  localparam int unsigned CTRL_SLIP_BIT  = 0;
  localparam int unsigned CTRL_SCE_BIT   = 1;
  localparam int unsigned CTRL_PAT_LSB   = 4;
  localparam int unsigned CTRL_RESTART   = 8;
  localparam int unsigned STAT_BUS_BIT   = 16;
  localparam int unsigned STAT_REQ_BIT   = 17;
  localparam int unsigned IRQ_BITS       = 3;
  localparam int unsigned IRQ_LOCK_BIT   = 0;
  localparam int unsigned IRQ_OVF_BIT    = 1;
  localparam int unsigned IRQ_UNF_BIT    = 2;
  localparam logic [3:0]  CTRL_PAT_RST   = 4'h5;
  localparam logic [1:0]  CTRL_LOW_RST   = 2'h2;
  localparam logic [2:0]  IRQ_EN_RST     = 3'h0;

  typedef enum logic [2:0] {
    SRD_WAIT   = 3'h0,
    SRD_EDGE1  = 3'h1,
    SRD_EDGE2  = 3'h3,
    SRD_CENTER = 3'h2,
    SRD_WORD   = 3'h6,
    SRD_DONE   = 3'h7
  } srd_state_e;
endpackage : srd_pkg

// [tb/srd_peer_tx.sv]
// Purpose: Peer transmitter model driving the sixteen differential lanes
// Assumes: Forwarded clock is CLK_SYS; one bit per cycle per lane
// Notes:   Per-lane skew lets each lane need its own slip count
`timescale 1ns/100ps
module srd_peer_tx
  import srd_pkg::*;
(
  input  wire logic                   CLK_SYS,
  input  wire logic                   CLOCK_REQUEST,
  input  wire logic [WORD_BITS-1:0]   PATTERN,
  input  wire logic [2*NUM_LANES-1:0] SKEW,
  output logic      [NUM_LANES-1:0]   LANE_IN_POS,
  output logic      [NUM_LANES-1:0]   LANE_IN_NEG
);
  logic [1:0] frame_r = 2'h0;
  logic [1:0] idx;

  always @(posedge CLK_SYS)
  begin
    frame_r <= frame_r + 2'h1;
    for (int i = 0; i < NUM_LANES; i++)
    begin
      idx = frame_r + SKEW[2*i +: 2];
      // Toggling lanes while asked, else training word oldest bit first
      LANE_IN_POS[i] <= CLOCK_REQUEST ? ~idx[0] : PATTERN[2'h3 - idx];
      LANE_IN_NEG[i] <= CLOCK_REQUEST ? idx[0] : ~PATTERN[2'h3 - idx];
    end
  end
endmodule : srd_peer_tx

// [tb/tb.sv]
// Purpose: Self-checking bench for the sixteen-lane receive deserializer
// Assumes: Zero-wait APB slave; single fast clock
// Notes:   Lock is awaited under a bound, never a fixed delay
`timescale 1ns/100ps
module tb;
  import srd_pkg::*;
  logic                 clk_sys = 0, rst_n = 0, logic_reset = 0, deser_reset = 0;
  logic                 delay_ready = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0, prdata, rd;
  logic                 pready, pslverr, data_valid, bus_locked, clock_request, irq, e;
  logic [BUS_BITS-1:0]  data_out;
  logic [NUM_LANES-1:0] lane_locked, lane_pos, lane_neg;
  logic [3:0]           pattern = 4'h5;
  logic [31:0]          skew = 32'h0;
  int                   err_total = 0, checks_done = 0, seed = 8, n;

  srd_rx_deser DUT (.CLK_SYS(clk_sys), .RST_N(rst_n), .LOGIC_RESET(logic_reset),
    .DESER_RESET(deser_reset), .DELAY_READY(delay_ready), .LANE_IN_POS(lane_pos),
    .LANE_IN_NEG(lane_neg), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DATA_OUT(data_out), .DATA_VALID(data_valid),
    .LANE_LOCKED(lane_locked), .BUS_LOCKED(bus_locked),
    .CLOCK_REQUEST(clock_request), .IRQ(irq));

  srd_peer_tx PEER (.CLK_SYS(clk_sys), .CLOCK_REQUEST(clock_request), .PATTERN(pattern),
    .SKEW(skew), .LANE_IN_POS(lane_pos), .LANE_IN_NEG(lane_neg));

  always #5 clk_sys = ~clk_sys;

  task report_and_stop;
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [63:0] exp_bus(input logic [3:0] p);
    return {16{p}};
  endfunction : exp_bus

  // Random training word and lane skews; all-equal words give no framing
  task pick;
    logic [3:0] p;
    p = 4'h0;
    while (p == 4'h0 || p == 4'hF)
      p = 4'($random(seed));
    pattern <= p;
    skew <= $random(seed);
    @(posedge clk_sys);
  endtask : pick

  task wait_valid;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (data_valid !== 1'b1 && n < 100);
    chk(data_valid, 1'b1);
  endtask : wait_valid

  task lock_and_check;
    n = 0;
    while (bus_locked !== 1'b1 && n < 8000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(bus_locked, 1'b1);
    chk(clock_request, 1'b0);
    repeat (3) wait_valid();
    chk(data_out, exp_bus(pattern));
    wait_valid();
    chk(n, 4);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0001FFFF);
  endtask : lock_and_check

  always @(posedge clk_sys)
    if (bus_locked === 1'b1)
      chk(lane_locked, 16'hFFFF);

  initial
  begin
    #400000;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    repeat (19) @(posedge clk_sys);
    chk({lane_locked, data_valid, irq, pready}, 19'h00001);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h00000052);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_IRQ_EN, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({e, rd}, 33'h100000000);
    pick();
    apb(1'b1, OFS_CTRL, {24'h0, pattern, 4'h3});
    repeat (50) @(posedge clk_sys);
    chk({clock_request, lane_locked, data_valid}, 18'h0);
    delay_ready <= 1'b1;
    n = 0;
    while (clock_request !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(clock_request, 1'b1);
    lock_and_check();
    // Lock event is sticky but masked until enabled
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({rd[IRQ_LOCK_BIT], irq}, 2'h2);
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    apb(1'b1, OFS_IRQ_CLR, 32'h1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({rd[IRQ_LOCK_BIT], irq}, 2'h0);
    // Capture stopped: a new training word must not reach the output
    apb(1'b1, OFS_CTRL, {24'h0, pattern, 4'h1});
    pattern <= pattern ^ 4'h6;
    repeat (40) @(posedge clk_sys);
    chk(data_out, exp_bus(pattern ^ 4'h6));
    logic_reset <= 1'b1;
    deser_reset <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({lane_locked, bus_locked}, 17'h0);
    logic_reset <= 1'b0;
    deser_reset <= 1'b0;
    pick();
    apb(1'b1, OFS_CTRL, {23'h0, 1'b1, pattern, 4'h3});
    lock_and_check();
    report_and_stop();
  end
endmodule : tb
